// >>> design/asp_map.svh
// register map, pin field positions and timing counts of the serial output port
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
`define ASP_REG_CTRL      4'h0
`define ASP_REG_STATUS    4'h4
`define ASP_REG_CONFIG    4'h8
`define ASP_CTRL_INIT     0
`define ASP_CTRL_MUTE     1
`define ASP_CTRL_RST      1'b0
`define ASP_PIN_BCK       0
`define ASP_PIN_WORD_SELECT_CLOCK      1
`define ASP_PIN_FMT       2
`define ASP_PIN_RATE      4
`define ASP_PIN_HPF       7
`define ASP_PIN_MST       8
`define ASP_PIN_RSTN      9
`define ASP_PIN_RST_VAL   10'h200
`define ASP_INIT_CYCLES   1024
`define ASP_INIT_LAST     10'(`ASP_INIT_CYCLES - 1)
`define ASP_HALF_SINGLE   7'h40
`define ASP_HALF_MULTI    7'h20
`define ASP_WORD_BITS     7'h18
`define ASP_HPF_SHIFT     15
`define ASP_ACC_W         40
`define ASP_CLIP_LOG2_N   7
`define ASP_CLIP_W        20
`endif

// >>> design/asp_pkg.sv
// types shared by the serial output port
package asp_pkg;
	typedef enum logic [1:0] {
		FMT_LJ     = 2'h0,
		FMT_I2S    = 2'h1,
		FMT_RJ     = 2'h2,
		FMT_STREAM = 2'h3
	} asp_fmt_t;
	typedef enum logic [2:0] {
		ST_HOLD = 3'h1,
		ST_INIT = 3'h2,
		ST_RUN  = 3'h4
	} asp_state_t;
	typedef struct packed {
		logic     master;
		asp_fmt_t fmt;
		logic [2:0] rate;
	} asp_cfg_t;
	typedef struct packed {
		logic signed [25:0] left;
		logic signed [25:0] right;
	} asp_pair_t;
endpackage : asp_pkg

// >>> design/asp_serial_port.sv
// serial output port: pcm/stream serializer, dc filter, clip flags, init sequencer
`timescale 1ns/1ns
`include "asp_map.svh"
module asp_serial_port
	import asp_pkg::*;
#(
	parameter int unsigned CLIP_HOLD_UNIT = 256   // hold length unit, 128 sample periods each in single rate
)(
	input  wire logic        clk,                   // system clock, 10 MHz
	input  wire logic        sys_rst,               // synchronous reset, high
	input  wire logic        ce,                    // clock enable
	input  wire logic [3:0]  avs_address,           // byte address
	input  wire logic        avs_read,              // read request
	input  wire logic        avs_write,             // write request
	input  wire logic [31:0] avs_writedata,         // write data
	output logic      [31:0] avs_readdata,          // read data
	output logic             avs_waitrequest,       // stall
	input  wire logic        ext_reset_n,           // reset pin, low
	input  wire logic        master_sel,            // 1 master, 0 slave
	input  wire logic        format_sel_0,          // format select bit 0
	input  wire logic        format_sel_1,          // format select bit 1
	input  wire logic        rate_sel_0,            // sampling mode bit 0
	input  wire logic        rate_sel_1,            // sampling mode bit 1
	input  wire logic        rate_sel_2,            // sampling mode bit 2
	input  wire logic        highpass_disable,      // 1 bypasses dc filter
	input  wire logic        serial_bit_clock_in,   // bit clock pin in
	output logic             serial_bit_clock_out,  // bit clock pin out
	output logic             serial_bit_clock_oe,   // bit clock drive enable
	input  wire logic        word_select_clock_in,  // word clock pin in
	output logic             word_select_clock_out, // word clock pin out
	output logic             word_select_clock_oe,  // word clock drive enable
	output logic             serial_sample_out,     // pcm data
	output logic             stream_bit_clock,      // stream clock
	output logic             stream_left_out,       // stream left data
	output logic             stream_right_out,      // stream right data
	input  asp_pair_t        filt_sample,           // decimation output
	input  wire logic        filt_valid,            // one pulse per sample
	input  wire logic        mod_left,              // modulator bit left
	input  wire logic        mod_right,             // modulator bit right
	output logic             overrange_flag_left,   // clip flag left
	output logic             overrange_flag_right   // clip flag right
);

	function automatic logic [2:0] bck_div(input logic [2:0] rate);
		unique case (rate[1:0])
			2'h0: bck_div = 3'h6;
			2'h1: bck_div = 3'h4;
			2'h2: bck_div = 3'h3;
			2'h3: bck_div = 3'h2;
		endcase
	endfunction : bck_div

	function automatic logic [23:0] sat24(input logic signed [25:0] v);
		if (v > 26'sh07FFFFF)
			sat24 = 24'h7FFFFF;
		else if (v < -26'sh0800000)
			sat24 = 24'h800000;
		else
			sat24 = v[23:0];
	endfunction : sat24

	function automatic logic pick_bit(input logic [23:0] w, input logic [6:0] p,
		input asp_fmt_t f, input logic [6:0] half);
		logic [6:0] start;
		logic [6:0] i;
		unique case (f)
			FMT_I2S: start = 7'h01;
			FMT_RJ:  start = 7'(half - `ASP_WORD_BITS);
			default: start = 7'h00;
		endcase
		i = 7'(p - start);
		if (p >= start && i < `ASP_WORD_BITS)
			pick_bit = w[5'(7'h17 - i)];
		else
			pick_bit = 1'b0;
	endfunction : pick_bit

	// pin synchronisers
	logic [9:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r;
	logic [9:0] pin_raw, pin_agree, pin_f_nxt;
	assign pin_raw = {ext_reset_n, master_sel, highpass_disable, rate_sel_2, rate_sel_1,
		rate_sel_0, format_sel_1, format_sel_0, word_select_clock_in, serial_bit_clock_in};
	assign pin_agree = ~(pin_s2_r ^ pin_s3_r);
	// value the filter takes at this edge, so a word clock edge meets its bit clock fall
	assign pin_f_nxt = (pin_s2_r & pin_agree) | (pin_f_r & ~pin_agree);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_s1_r <= `ASP_PIN_RST_VAL;
			pin_s2_r <= `ASP_PIN_RST_VAL;
			pin_s3_r <= `ASP_PIN_RST_VAL;
			pin_f_r  <= `ASP_PIN_RST_VAL;
		end else if (ce) begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_f_r  <= pin_f_nxt;
		end
	end

	logic s_bck_fall;
	assign s_bck_fall = pin_f_r[`ASP_PIN_BCK] & pin_agree[`ASP_PIN_BCK]
		& ~pin_s2_r[`ASP_PIN_BCK];

	// bus slave
	logic        wait_r, mute_r;
	logic [31:0] rdata_r, rdata_nxt;
	logic        wr_take, soft_init;
	assign wr_take = ce & avs_write & ~wait_r;
	assign soft_init = wr_take & (avs_address == `ASP_REG_CTRL)
		& avs_writedata[`ASP_CTRL_INIT];

	// init sequencer
	asp_state_t st_r;
	logic [9:0] init_cnt_r;
	logic       run;
	assign run = (st_r == ST_RUN);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r       <= ST_INIT;
			init_cnt_r <= 10'h000;
		end else if (ce) begin
			if (!pin_f_r[`ASP_PIN_RSTN]) begin
				st_r       <= ST_HOLD;
				init_cnt_r <= 10'h000;
			end else begin
				unique case (st_r)
					ST_HOLD: begin
						st_r       <= ST_INIT;
						init_cnt_r <= 10'h000;
					end
					ST_INIT: begin
						if (init_cnt_r == `ASP_INIT_LAST)
							st_r <= ST_RUN;
						else
							init_cnt_r <= init_cnt_r + 10'h001;
					end
					ST_RUN: begin
						if (soft_init) begin
							st_r       <= ST_INIT;
							init_cnt_r <= 10'h000;
						end
					end
				endcase
			end
		end
	end

	// mode pins are captured while not running; changes need a new init
	asp_cfg_t cfg_r;
	always_ff @(posedge clk) begin
		if (sys_rst)
			cfg_r <= '0;
		else if (ce && !run)
			cfg_r <= {pin_f_r[`ASP_PIN_MST], pin_f_r[`ASP_PIN_FMT +: 2],
				pin_f_r[`ASP_PIN_RATE +: 3]};
	end

	logic       is_stream, master_eff;
	logic [2:0] div, hdiv;
	logic [6:0] half, half_m1;
	assign is_stream  = (cfg_r.fmt == FMT_STREAM);
	assign master_eff = cfg_r.master | is_stream;
	assign div        = bck_div(cfg_r.rate);
	assign hdiv       = div >> 1;
	assign half       = cfg_r.rate[2] ? `ASP_HALF_MULTI : `ASP_HALF_SINGLE;
	assign half_m1    = half - 7'h01;

	// clock divider shared by bit clock and stream clock
	logic [2:0] dcnt_r;
	logic       clk_lvl_r, m_fall, m_rise, clk_nxt, fall_evt;
	assign m_fall  = run & master_eff & (dcnt_r == div - 3'h1);
	assign m_rise  = run & master_eff & (dcnt_r == hdiv - 3'h1);
	assign clk_nxt = m_fall ? 1'b0 : (m_rise ? 1'b1 : (clk_lvl_r & run & master_eff));
	assign fall_evt = master_eff ? m_fall : (run & s_bck_fall);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dcnt_r    <= 3'h0;
			clk_lvl_r <= 1'b0;
		end else if (ce) begin
			clk_lvl_r <= clk_nxt;
			if (!run || !master_eff || m_fall)
				dcnt_r <= 3'h0;
			else
				dcnt_r <= dcnt_r + 3'h1;
		end
	end

	// slot tracking
	logic [6:0]  p_r, p_nxt;
	logic        lvl_r, lvl_nxt, new_half, left_side;
	logic [23:0] word_r, word_nxt;
	logic [23:0] chan_r [2];
	always_comb begin
		if (master_eff) begin
			new_half = (p_r >= half_m1);
			lvl_nxt  = new_half ? ~lvl_r : lvl_r;
		end else begin
			lvl_nxt  = pin_f_nxt[`ASP_PIN_WORD_SELECT_CLOCK];
			new_half = (lvl_nxt != lvl_r);
		end
		if (new_half)
			p_nxt = 7'h00;
		else if (p_r == 7'h7F)
			p_nxt = p_r;
		else
			p_nxt = p_r + 7'h01;
		left_side = (cfg_r.fmt == FMT_I2S) ? ~lvl_nxt : lvl_nxt;
		word_nxt  = new_half ? (left_side ? chan_r[0] : chan_r[1]) : word_r;
	end

	logic sample_r, wsel_r, bck_r, bck_oe_r, wsel_oe_r, sclk_r, sl_r, sr_r;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			p_r      <= 7'h7F;
			lvl_r    <= 1'b0;
			word_r   <= 24'h000000;
			sample_r <= 1'b0;
			wsel_r   <= 1'b0;
		end else if (ce) begin
			if (!run || is_stream) begin
				p_r      <= 7'h7F;
				lvl_r    <= 1'b0;
				sample_r <= 1'b0;
				wsel_r   <= 1'b0;
			end else if (fall_evt) begin
				p_r      <= p_nxt;
				lvl_r    <= lvl_nxt;
				word_r   <= word_nxt;
				sample_r <= ~mute_r & pick_bit(word_nxt, p_nxt, cfg_r.fmt, half);
				if (master_eff)
					wsel_r <= lvl_nxt;
			end else if (mute_r) begin
				sample_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bck_r     <= 1'b0;
			bck_oe_r  <= 1'b0;
			wsel_oe_r <= 1'b0;
			sclk_r    <= 1'b0;
			sl_r      <= 1'b0;
			sr_r      <= 1'b0;
		end else if (ce) begin
			bck_r     <= clk_nxt & ~is_stream;
			bck_oe_r  <= cfg_r.master & ~is_stream;
			wsel_oe_r <= cfg_r.master & ~is_stream;
			sclk_r    <= clk_nxt & is_stream;
			if (!run || !is_stream) begin
				sl_r <= 1'b0;
				sr_r <= 1'b0;
			end else if (m_fall) begin
				sl_r <= mod_left;
				sr_r <= mod_right;
			end
		end
	end

	// dc removal and clip detection per channel
	logic [`ASP_CLIP_W-1:0] hold_last;
	logic [1:0]             clip_r;
	logic [23:0]            sat_x [2];
	logic [1:0]             over;
	logic                   pcm_take;
	assign hold_last = `ASP_CLIP_W'((CLIP_HOLD_UNIT << (`ASP_CLIP_LOG2_N
		+ (cfg_r.rate[2] ? (cfg_r.rate[1] ? 2 : 1) : 0))) - 1);
	assign pcm_take = ce & run & ~is_stream & filt_valid;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic signed [25:0]            x;
			logic signed [`ASP_ACC_W-1:0]  acc_r;
			logic signed [23:0]            dc;
			logic signed [25:0]            y;
			logic [`ASP_CLIP_W-1:0]        hcnt_r;
			assign x        = (g == 0) ? filt_sample.left : filt_sample.right;
			assign sat_x[g] = sat24(x);
			assign over[g]  = (x > 26'sh07FFFFF) || (x < -26'sh0800000);
			assign dc       = acc_r[`ASP_HPF_SHIFT +: 24];
			assign y        = 26'(signed'(sat_x[g])) - 26'(dc);

			always_ff @(posedge clk) begin
				if (sys_rst || (ce && !run)) begin
					acc_r     <= '0;
					chan_r[g] <= 24'h000000;
				end else if (pcm_take) begin
					// once per sample, so the corner tracks the sample rate
					acc_r <= acc_r + `ASP_ACC_W'(signed'(sat_x[g]))
						- `ASP_ACC_W'(dc);
					if (pin_f_r[`ASP_PIN_HPF])
						chan_r[g] <= sat_x[g];
					else
						chan_r[g] <= sat24(y);
				end
			end

			always_ff @(posedge clk) begin
				if (sys_rst) begin
					clip_r[g] <= 1'b0;
					hcnt_r    <= '0;
				end else if (ce) begin
					if (!run || is_stream) begin
						clip_r[g] <= 1'b0;
						hcnt_r    <= '0;
					end else if (filt_valid && over[g]) begin
						clip_r[g] <= 1'b1;
						hcnt_r    <= '0;
					end else if (filt_valid && clip_r[g]) begin
						if (hcnt_r >= hold_last) begin
							clip_r[g] <= 1'b0;
							hcnt_r    <= '0;
						end else begin
							hcnt_r <= hcnt_r + `ASP_CLIP_W'(1);
						end
					end
				end
			end
		end
	endgenerate

	// register access, one wait cycle per request
	always_comb begin
		unique case (avs_address)
			`ASP_REG_CTRL:   rdata_nxt = {30'h0, mute_r, 1'b0};
			`ASP_REG_STATUS: rdata_nxt = {27'h0, clip_r, st_r};
			`ASP_REG_CONFIG: rdata_nxt = {25'h0, pin_f_r[`ASP_PIN_HPF], cfg_r};
			default:         rdata_nxt = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h00000000;
			mute_r  <= `ASP_CTRL_RST;
		end else if (ce) begin
			if ((avs_read || avs_write) && wait_r) begin
				wait_r  <= 1'b0;
				rdata_r <= avs_read ? rdata_nxt : 32'h00000000;
			end else if (!wait_r) begin
				wait_r <= 1'b1;
			end
			if (wr_take && avs_address == `ASP_REG_CTRL)
				mute_r <= avs_writedata[`ASP_CTRL_MUTE];
		end
	end

	assign avs_readdata          = rdata_r;
	assign avs_waitrequest       = wait_r;
	assign serial_bit_clock_out  = bck_r;
	assign serial_bit_clock_oe   = bck_oe_r;
	assign word_select_clock_out = wsel_r;
	assign word_select_clock_oe  = wsel_oe_r;
	assign serial_sample_out     = sample_r;
	assign stream_bit_clock      = sclk_r;
	assign stream_left_out       = sl_r;
	assign stream_right_out      = sr_r;
	assign overrange_flag_left   = clip_r[0];
	assign overrange_flag_right  = clip_r[1];

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_wrap;
		ce && m_fall && !is_stream && p_r == half_m1;
	endsequence
	sequence s_half_start;
		p_r == 7'h00 && $changed(lvl_r);
	endsequence

	property p_init_len;
		$rose(st_r == ST_RUN) |-> $past(init_cnt_r) == `ASP_INIT_LAST;
	endproperty
	a_init_len: assert property (p_init_len) else $error("init length wrong");

	property p_init_quiet;
		$past(ce) && $past(st_r) != ST_RUN |-> !sample_r && !sl_r && !sr_r;
	endproperty
	a_init_quiet: assert property (p_init_quiet) else $error("data during init");

	property p_shift_fall;
		$changed(sample_r) |-> $past(fall_evt) || $past(!run) || $past(mute_r);
	endproperty
	a_shift_fall: assert property (p_shift_fall) else $error("data off falling edge");

	property p_master_clk;
		ce && m_fall && !is_stream |=> !bck_r && bck_oe_r && wsel_oe_r;
	endproperty
	a_master_clk: assert property (p_master_clk) else $error("master clock not driven");

	property p_bck_ratio;
		s_wrap |=> s_half_start;
	endproperty
	a_bck_ratio: assert property (p_bck_ratio) else $error("half frame length wrong");

	property p_word_select_clock_half;
		run && $past(run) && $changed(wsel_r) |-> $past(m_fall && p_r >= half_m1);
	endproperty
	a_word_select_clock_half: assert property (p_word_select_clock_half) else $error("word clock off boundary");

	property p_stream_data;
		ce && run && is_stream && m_fall |=> sl_r == $past(mod_left) && sr_r == $past(mod_right);
	endproperty
	a_stream_data: assert property (p_stream_data) else $error("stream data not taken");

	property p_stream_clk;
		run && $past(run) && $changed(sclk_r) |-> $past((m_fall || m_rise) && is_stream);
	endproperty
	a_stream_clk: assert property (p_stream_clk) else $error("stream clock not divided");

	property p_hpf_bypass;
		pcm_take && pin_f_r[`ASP_PIN_HPF] |=> chan_r[0] == $past(sat_x[0]);
	endproperty
	a_hpf_bypass: assert property (p_hpf_bypass) else $error("bypass altered sample");

	property p_clip_set;
		ce && run && !is_stream && filt_valid && over[1] |=> clip_r[1];
	endproperty
	a_clip_set: assert property (p_clip_set) else $error("clip flag not raised");

	property p_clip_set_l;
		ce && run && !is_stream && filt_valid && over[0] |=> clip_r[0];
	endproperty
	a_clip_set_l: assert property (p_clip_set_l) else $error("left clip flag not raised");

	property p_clip_stream;
		$past(ce && is_stream) |-> clip_r == 2'h0;
	endproperty
	a_clip_stream: assert property (p_clip_stream) else $error("clip in stream mode");

endmodule : asp_serial_port

// >>> verif/asp_capture_model.sv
// far-side capture device: slave clock source and serial data capture
`timescale 1ns/1ns
module asp_capture_model (
	input  wire logic        clk,      // system clock
	input  wire logic        sys_rst,  // synchronous reset, high
	input  wire logic        slave_en, // 1 supplies bit and word clocks
	input  wire logic        serial_bit_clock,      // bit clock on the wire
	input  wire logic        wck,      // word clock on the wire
	input  wire logic        sdata,    // serial data on the wire
	output logic             bck_drv,  // bit clock for slave mode
	output logic             wck_drv,  // word clock for slave mode
	output logic [63:0]      cap_r,    // bits since the last word clock edge
	output logic [6:0]       cnt_r,    // bits taken in this half
	output logic             bad_r     // data moved while bit clock high
);
	logic [10:0] div_r;
	logic        bck_q;
	logic        wck_q;
	logic        dat_q;
	// one counter makes both clocks, so they cannot slip apart
	always_ff @(posedge clk) begin
		if (sys_rst || !slave_en) begin
			div_r <= 11'h0;
		end else begin
			div_r <= div_r + 11'h1;
		end
	end
	assign bck_drv = div_r[3];
	assign wck_drv = div_r[10];
	always_ff @(posedge clk) begin
		bck_q <= serial_bit_clock;
		dat_q <= sdata;
		if (sys_rst) begin
			bad_r <= 1'b0;
		end else if (serial_bit_clock && bck_q && sdata != dat_q) begin
			bad_r <= 1'b1;
		end
		if (serial_bit_clock && !bck_q) begin
			wck_q <= wck;
			cap_r <= (wck != wck_q) ? {63'h0, sdata} : {cap_r[62:0], sdata};
			cnt_r <= (wck != wck_q) ? 7'h1 : cnt_r + 7'h1;
		end
	end
endmodule : asp_capture_model

// >>> verif/test_stereo_adc_serial_output_port.sv
// self-checking bench of the serial output port
`timescale 1ns/1ns
module test_stereo_adc_serial_output_port;
	import asp_pkg::*;
	logic        clk, sys_rst, ce, avs_read, avs_write, avs_waitrequest;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic        ext_reset_n, ms, hpd, slave_en, filt_valid, mod_left, mod_right;
	logic [1:0]  fmt;
	logic [2:0]  rate, fv_cnt;
	logic        bck_o, bck_oe, wck_o, wck_oe, sdo, sbck, sdl, sdr, fl, fr;
	logic        bck_d, wck_d, bad;
	logic [63:0] cap_bits;
	logic [6:0]  cnt;
	asp_pair_t   samp;
	int          checks, miscompares;
	// an undriven clock line sits low, as if pulled down
	wire bck_w = bck_oe ? bck_o : (slave_en ? bck_d : 1'b0);
	wire wck_w = wck_oe ? wck_o : (slave_en ? wck_d : 1'b0);
	localparam asp_pair_t NORM = '{26'h05A5A5A, 26'h3A5A5A5};
	localparam asp_pair_t OVER = '{26'h1000000, 26'h3A5A5A5};
	asp_serial_port #(.CLIP_HOLD_UNIT(1)) i_dut (
		.clk(clk), .sys_rst(sys_rst), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_reset_n(ext_reset_n), .master_sel(ms), .format_sel_0(fmt[0]),
		.format_sel_1(fmt[1]), .rate_sel_0(rate[0]), .rate_sel_1(rate[1]),
		.rate_sel_2(rate[2]), .highpass_disable(hpd), .serial_bit_clock_in(bck_w),
		.serial_bit_clock_out(bck_o), .serial_bit_clock_oe(bck_oe),
		.word_select_clock_in(wck_w), .word_select_clock_out(wck_o),
		.word_select_clock_oe(wck_oe), .serial_sample_out(sdo), .stream_bit_clock(sbck),
		.stream_left_out(sdl), .stream_right_out(sdr), .filt_sample(samp),
		.filt_valid(filt_valid), .mod_left(mod_left), .mod_right(mod_right),
		.overrange_flag_left(fl), .overrange_flag_right(fr));
	asp_capture_model i_far (.clk(clk), .sys_rst(sys_rst), .slave_en(slave_en),
		.serial_bit_clock(bck_w), .wck(wck_w), .sdata(sdo), .bck_drv(bck_d), .wck_drv(wck_d),
		.cap_r(cap_bits), .cnt_r(cnt), .bad_r(bad));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always_ff @(posedge clk) begin
		fv_cnt <= sys_rst ? 3'h0 : fv_cnt + 3'h1;
		filt_valid <= (fv_cnt == 3'h7);
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		check(n, 2);
	endtask : bus
	task automatic status(input logic [2:0] exp);
		logic [31:0] d;
		bus(1'b0, 4'h4, 32'h0, d);
		check(d[2:0], exp);
	endtask : status
	task automatic restart(input logic m, input logic [1:0] f, input logic [2:0] r);
		logic z;
		int   i;
		@(posedge clk);
		ms <= m;
		fmt <= f;
		rate <= r;
		ext_reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		status(3'h1);
		ext_reset_n <= 1'b1;
		z = 1'b0;
		for (i = 0; i < 1000; i++) begin
			@(posedge clk);
			z = z | sdo | sdl | sdr;
		end
		check(z, 1'b0);
		status(3'h2);
		repeat (40) @(posedge clk);
		status(3'h4);
	endtask : restart
	task automatic meas(input int s, output int n);
		logic p;
		logic c;
		int   k;
		n = 0;
		p = 1'b1;
		for (k = 0; k < 3000; k++) begin
			@(posedge clk);
			c = (s == 0) ? bck_w : (s == 1) ? wck_w : sbck;
			if (c && !p) begin
				if (n > 0) break;
				n = 1;
			end else if (n > 0) n++;
			p = c;
		end
	endtask : meas
	task automatic cap(input logic [6:0] c, input logic l, output logic [23:0] v);
		int k;
		v = 24'h0;
		for (k = 0; k < 5000; k++) begin
			@(posedge clk);
			if (cnt === c && wck_w === l) begin
				v = cap_bits[23:0];
				break;
			end
		end
	endtask : cap
	task automatic wait_pulse;
		do @(posedge clk); while (filt_valid !== 1'b1);
	endtask : wait_pulse
	task automatic t_regs;
		logic [31:0] d;
		bus(1'b0, 4'h8, 32'h0, d);
		check(d, 32'h00000060);
		bus(1'b1, 4'hC, 32'hFFFFFFFF, d);
		bus(1'b0, 4'hC, 32'h0, d);
		check(d, 32'h0);
		bus(1'b1, 4'h0, 32'h00000002, d);
		bus(1'b0, 4'h0, 32'h0, d);
		check(d, 32'h00000002);
		bus(1'b1, 4'h0, 32'h0, d);
		bus(1'b1, 4'h0, 32'h00000001, d);
		status(3'h2);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_freeze;
		logic [3:0] s;
		@(posedge clk);
		ce <= 1'b0;
		@(posedge clk);
		s = {bck_o, wck_o, sdo, avs_waitrequest};
		repeat (12) begin
			@(posedge clk);
			check({bck_o, wck_o, sdo, avs_waitrequest}, s);
		end
		ce <= 1'b1;
		$display("t_freeze done");
	endtask : t_freeze
	task automatic t_clocks;
		int b[3] = '{6, 6, 3};
		int w[3] = '{768, 384, 192};
		logic [2:0] r[3] = '{3'h0, 3'h4, 3'h6};
		int i;
		int n;
		for (i = 0; i < 3; i++) begin
			restart(1'b1, 2'h0, r[i]);
			check(bck_oe & wck_oe, 1'b1);
			meas(0, n);
			check(n, b[i]);
			meas(1, n);
			check(n, w[i]);
		end
		$display("t_clocks done");
	endtask : t_clocks
	task automatic t_formats;
		logic [6:0] c[3] = '{7'h18, 7'h19, 7'h40};
		logic [23:0] v;
		int i;
		for (i = 0; i < 3; i++) begin
			restart(1'b1, i[1:0], 3'h0);
			repeat (800) @(posedge clk);
			cap(c[i], i != 1, v);
			check(v, 24'h5A5A5A);
		end
		$display("t_formats done");
	endtask : t_formats
	task automatic t_slave;
		logic [23:0] v;
		slave_en <= 1'b1;
		restart(1'b0, 2'h0, 3'h0);
		check(bck_oe | wck_oe, 1'b0);
		repeat (2100) @(posedge clk);
		cap(7'h18, 1'b1, v);
		check(v, 24'h5A5A5A);
		hpd <= 1'b0;
		repeat (2048) @(posedge clk);
		cap(7'h18, 1'b1, v);
		check((v < 24'h5A5A5A) && (v > 24'h400000), 1'b1);
		hpd <= 1'b1;
		slave_en <= 1'b0;
		$display("t_slave done");
	endtask : t_slave
	task automatic t_clip;
		restart(1'b1, 2'h0, 3'h0);
		samp <= OVER;
		wait_pulse;
		samp <= NORM;
		@(posedge clk);
		check({fl, fr}, 2'b10);
		repeat (127) wait_pulse;
		@(posedge clk);
		check(fl, 1'b1);
		wait_pulse;
		@(posedge clk);
		check(fl, 1'b0);
		$display("t_clip done");
	endtask : t_clip
	task automatic t_stream;
		int n;
		restart(1'b1, 2'h3, 3'h0);
		check(bck_oe, 1'b0);
		meas(2, n);
		check(n, 6);
		samp <= OVER;
		mod_left <= 1'b1;
		mod_right <= 1'b0;
		repeat (20) @(posedge clk);
		check({sdl, sdr}, 2'b10);
		mod_left <= 1'b0;
		mod_right <= 1'b1;
		repeat (20) @(posedge clk);
		check({sdl, sdr}, 2'b01);
		check({fl, fr, sdo}, 3'b000);
		samp <= NORM;
		$display("t_stream done");
	endtask : t_stream
	initial begin
		checks = 0;
		miscompares = 0;
		sys_rst = 1'b1;
		ce = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		ext_reset_n = 1'b1;
		ms = 1'b1;
		hpd = 1'b1;
		fmt = 2'h0;
		rate = 3'h0;
		slave_en = 1'b0;
		mod_left = 1'b0;
		mod_right = 1'b0;
		samp = NORM;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		status(3'h2);
		repeat (1030) @(posedge clk);
		status(3'h4);
		t_freeze;
		t_regs;
		t_clocks;
		t_formats;
		t_slave;
		t_clip;
		t_stream;
		check(bad, 1'b0);
		final_report;
	end
	initial begin
		#5000000;
		miscompares++;
		final_report;
	end
endmodule : test_stereo_adc_serial_output_port
